/* dv/sbcr_props.sv */
// Concurrent checks on the command and response link
`timescale 1ns/1ps
module sbcr_props
  import sbcr_pkg::*;
#(
  parameter int NORMAL_CYCLES = 50
) (
  // Clock and reset
  input wire logic        i_clock,
  input wire logic        i_rst,
  // Command side
  input wire logic        cmd_valid,
  input wire logic        cmd_ready,
  input wire logic [7:0]  cmd_tag,
  input wire logic [7:0]  cmd_type,
  input wire logic        cmd_poll,
  input wire logic [7:0]  cmd_data,
  // Response side
  input wire logic        rsp_valid,
  input wire logic [7:0]  rsp_tag,
  input wire logic [7:0]  rsp_type,
  input wire logic [7:0]  rsp_code,
  input wire logic [7:0]  rsp_reason,
  input wire logic [7:0]  rsp_data,
  input wire logic [15:0] rsp_hint
);
  localparam int RSP_BOUND = NORMAL_CYCLES + 4;
  localparam int LATE_MIN  = NORMAL_CYCLES - 1;

  logic [31:0] wait_cnt;
  logic [31:0] next_wait_cnt;

  // Cycles since the pending command was taken
  always_comb begin
    next_wait_cnt = wait_cnt;
    if (cmd_valid && cmd_ready) begin
      next_wait_cnt = 32'h0;
    end else if (cmd_valid) begin
      next_wait_cnt = wait_cnt + 32'h1;
    end
  end

  // Register the wait count
  always_ff @(posedge i_clock) begin
    if (i_rst) begin
      wait_cnt <= 32'h0;
    end else begin
      wait_cnt <= next_wait_cnt;
    end
  end

  default clocking cb @(posedge i_clock);
  endclocking
  default disable iff (i_rst);

  // Command taken by the device, and its answer
  sequence s_take;
    cmd_valid && cmd_ready;
  endsequence
  sequence s_answer;
    rsp_valid;
  endsequence

  a_tag_nonzero: assert property (cmd_valid |-> cmd_tag != TAG_EVENT)
    else $error("command sent with tag zero");
  a_tag_echo: assert property (s_answer |-> rsp_tag == cmd_tag)
    else $error("response tag differs from command tag");
  a_type_echo: assert property (s_answer |-> rsp_type == cmd_type)
    else $error("response type differs from command type");
  a_one_outstanding: assert property (s_take |=> !cmd_ready)
    else $error("device ready again before answering");
  a_answer_bound: assert property (s_take |-> ##[1:RSP_BOUND] s_answer)
    else $error("no answer within the normal interval");
  a_poll_prompt: assert property (s_take ##0 cmd_poll |-> ##[1:2] s_answer)
    else $error("poll not answered promptly");
  a_unsup_reason: assert property (s_answer ##0 rsp_code == RESP_UNSUPPORTED
    |-> rsp_reason == REASON_UNKNOWN_TYPE) else $error("unsupported answer with wrong reason");
  a_delay_fields: assert property (s_answer ##0 rsp_code == RESP_DELAYED
    |-> rsp_reason == REASON_DELAYED && rsp_hint == POLL_HINT_US)
    else $error("delayed answer with wrong reason or hint");
  a_delay_late: assert property (s_answer ##0 rsp_code == RESP_DELAYED && !cmd_poll
    |-> wait_cnt >= 32'(LATE_MIN)) else $error("delayed answer before the normal interval");
  a_host_waits: assert property (s_answer |=> !cmd_valid)
    else $error("controller still holds a command after its answer");
  a_cmd_stable: assert property (cmd_valid |=> !cmd_valid
    || $stable({cmd_tag, cmd_type, cmd_poll, cmd_data})) else $error("command changed in flight");
endmodule

/* dv/sideband_command_responder_tb.sv */
// Self-checking bench joining controller and device ends
`timescale 1ns/1ps
`define CHK(g, e) begin n_tests++; if ((g) !== (e)) begin errors++; \
  $display("unexpected at %0t: got %h expected %h", $time, (g), (e)); end end
module sideband_command_responder_tb
  import sbcr_pkg::*;
;
  localparam int NORM = 50;
  logic       i_clock = 1'b0;
  logic       i_rst = 1'b1;
  logic       req_valid = 1'b0, req_retry = 1'b0, req_poll = 1'b0, req_ready;
  logic [7:0] req_type = 8'h00, req_data = 8'h00;
  logic       ans_valid, ans_match;
  logic [7:0] ans_code, ans_reason, ans_data;
  logic [15:0] ans_hint;
  logic       exec_start, exec_done = 1'b0, eng_ok = 1'b1, exec_early = 1'b0, busy = 1'b0;
  logic [7:0] exec_type, exec_data, exec_result = 8'h00;
  logic       ev_in_valid = 1'b0, ev_valid, enter_init = 1'b0, clear_init = 1'b0, init_state;
  logic [7:0] ev_in_code = 8'h00, ev_tag, ev_code;
  logic       eng_early = 1'b0;
  int         lat = 5, eng_cnt = 0, n_start = 0, errors = 0, n_tests = 0, cycles = 0;

  sbcr_if link ();
  sbcr_host i_sbcr_host (.i_clock(i_clock), .i_rst(i_rst), .link(link),
    .i_req_valid(req_valid), .i_req_type(req_type), .i_req_data(req_data),
    .i_req_retry(req_retry), .i_req_poll(req_poll), .o_req_ready(req_ready),
    .o_ans_valid(ans_valid), .o_ans_match(ans_match), .o_ans_code(ans_code),
    .o_ans_reason(ans_reason), .o_ans_data(ans_data), .o_ans_hint(ans_hint));
  sbcr_device #(.NORMAL_CYCLES(NORM), .OP_CYCLES(100), .DELAY_CYCLES(200), .TYPE_COUNT(8))
  i_sbcr_device (.i_clock(i_clock), .i_rst(i_rst), .link(link),
    .o_exec_start(exec_start), .o_exec_type(exec_type), .o_exec_data(exec_data),
    .i_exec_done(exec_done), .i_exec_ok(eng_ok), .i_exec_result(exec_result),
    .i_exec_early(exec_early), .i_busy(busy), .i_event_valid(ev_in_valid),
    .i_event_code(ev_in_code), .o_event_valid(ev_valid), .o_event_tag(ev_tag),
    .o_event_code(ev_code), .i_enter_initial(enter_init), .i_clear_initial(clear_init),
    .o_initial_state(init_state));
  sbcr_props #(.NORMAL_CYCLES(NORM)) i_sbcr_props (.i_clock(i_clock), .i_rst(i_rst),
    .cmd_valid(link.cmd_valid), .cmd_ready(link.cmd_ready), .cmd_tag(link.cmd_tag),
    .cmd_type(link.cmd_type), .cmd_poll(link.cmd_poll), .cmd_data(link.cmd_data),
    .rsp_valid(link.rsp_valid), .rsp_tag(link.rsp_tag), .rsp_type(link.rsp_type),
    .rsp_code(link.rsp_code), .rsp_reason(link.rsp_reason), .rsp_data(link.rsp_data),
    .rsp_hint(link.rsp_hint));

  // Clock source
  initial begin
    forever #2 i_clock = ~i_clock;
  end

  // Execution engine stand-in: finishes a started action after lat cycles
  always @(posedge i_clock) begin
    exec_done <= 1'b0;
    exec_early <= 1'b0;
    if (exec_start === 1'b1) begin
      n_start <= n_start + 1;
      eng_cnt <= lat;
      exec_result <= exec_data ^ 8'h5A;
      exec_early <= eng_early;
    end else if (eng_cnt == 1) begin
      exec_done <= 1'b1;
      eng_cnt <= 0;
    end else if (eng_cnt > 1) begin
      eng_cnt <= eng_cnt - 1;
    end
  end

  // Hang guard
  always @(posedge i_clock) begin
    cycles <= cycles + 1;
    if (cycles == 3000) begin
      errors++;
      finish_test();
    end
  end

  // Print counts and verdict, then stop
  task automatic finish_test();
    $display("checks %0d mismatches %0d", n_tests, errors);
    if (errors == 0 && n_tests > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask

  // Issue one request and wait for its answer
  task automatic send(input logic [7:0] t, d, input logic rt, pl);
    @(posedge i_clock);
    req_type <= t;
    req_data <= d;
    req_retry <= rt;
    req_poll <= pl;
    req_valid <= 1'b1;
    do @(negedge i_clock); while (req_ready !== 1'b1);
    @(posedge i_clock);
    req_valid <= 1'b0;
    do @(negedge i_clock); while (ans_valid !== 1'b1);
    `CHK(ans_match, 1'b1)
  endtask

  // Compare the latest answer code and reason
  task automatic expect_ans(input logic [7:0] code, reason);
    `CHK(ans_code, code)
    `CHK(ans_reason, reason)
  endtask

  // Pulse one control input for a cycle
  task automatic pulse_init(input logic enter);
    @(posedge i_clock);
    if (enter) enter_init <= 1'b1;
    else clear_init <= 1'b1;
    @(posedge i_clock);
    enter_init <= 1'b0;
    clear_init <= 1'b0;
    @(negedge i_clock);
  endtask

  // Main sequence
  initial begin
    int s;
    logic [7:0] t;
    repeat (5) @(posedge i_clock);
    i_rst <= 1'b0;
    @(negedge i_clock);
    `CHK(init_state, 1'b1)
    `CHK(link.cmd_ready, 1'b1)
    pulse_init(1'b0);
    `CHK(init_state, 1'b0)
    s = n_start;
    send(8'h01, 8'h11, 1'b0, 1'b0);
    expect_ans(RESP_OK, REASON_NONE);
    `CHK(ans_data, 8'h4B)
    `CHK(exec_type, 8'h01)
    `CHK(exec_data, 8'h11)
    send(8'h01, 8'h22, 1'b1, 1'b0);
    `CHK(ans_data, 8'h4B)
    `CHK(n_start, s + 1)
    send(8'h01, 8'h11, 1'b1, 1'b1);
    expect_ans(RESP_FAILED, REASON_NO_CMD);
    send(8'h01, 8'h11, 1'b1, 1'b0);
    expect_ans(RESP_FAILED, REASON_NO_CMD);
    send(8'h02, 8'h33, 1'b0, 1'b0);
    `CHK(ans_data, 8'h69)
    `CHK(n_start, s + 2)
    $display("test retry and poll done");
    for (int i = 0; i < 2; i++) begin
      t = (i == 0) ? 8'h08 : 8'hFF;
      send(t, 8'h00, 1'b0, 1'b0);
      expect_ans(RESP_UNSUPPORTED, REASON_UNKNOWN_TYPE);
    end
    @(posedge i_clock);
    busy <= 1'b1;
    send(8'h01, 8'h00, 1'b0, 1'b0);
    expect_ans(RESP_UNAVAILABLE, REASON_NONE);
    @(posedge i_clock);
    busy <= 1'b0;
    `CHK(n_start, s + 2)
    $display("test refusals done");
    lat <= 80;
    send(8'h03, 8'h44, 1'b0, 1'b0);
    expect_ans(RESP_DELAYED, REASON_DELAYED);
    `CHK(ans_hint, POLL_HINT_US)
    send(8'h03, 8'h44, 1'b1, 1'b1);
    expect_ans(RESP_DELAYED, REASON_DELAYED);
    repeat (40) @(posedge i_clock);
    send(8'h03, 8'h44, 1'b1, 1'b1);
    expect_ans(RESP_OK, REASON_NONE);
    `CHK(ans_data, 8'h1E)
    $display("test delayed done");
    @(posedge i_clock);
    ev_in_valid <= 1'b1;
    ev_in_code <= 8'h3C;
    @(posedge i_clock);
    ev_in_valid <= 1'b0;
    @(negedge i_clock);
    `CHK(ev_valid, 1'b1)
    `CHK(ev_tag, TAG_EVENT)
    `CHK(ev_code, 8'h3C)
    $display("test event done");
    lat <= 10;
    eng_early <= 1'b1;
    send(8'h04, 8'h55, 1'b0, 1'b0);
    expect_ans(RESP_OK, REASON_NONE);
    `CHK(ans_data, 8'h0F)
    @(posedge i_clock);
    eng_ok <= 1'b0;
    repeat (15) @(negedge i_clock);
    `CHK(init_state, 1'b1)
    @(posedge i_clock);
    eng_ok <= 1'b1;
    eng_early <= 1'b0;
    pulse_init(1'b0);
    s = n_start;
    send(8'h04, 8'h66, 1'b1, 1'b0);
    `CHK(ans_data, 8'h3C)
    `CHK(n_start, s + 1)
    pulse_init(1'b1);
    `CHK(init_state, 1'b1)
    pulse_init(1'b0);
    send(8'h04, 8'h77, 1'b1, 1'b0);
    `CHK(ans_data, 8'h2D)
    `CHK(n_start, s + 2)
    $display("test initial state done");
    finish_test();
  end
endmodule

/* hdl/sbcr_device.sv */
// Device end: takes commands, matches tags, answers, and runs the action
`timescale 1ns/1ps
// Notes on behaviour
// - Tags are 8-bit, one through 255, never zero
// - Response carries the command's own tag
// - Same tag as before: resend held response
// - Same tag with poll flag is status poll
// - Poll with nothing in progress gets error
// - Poll returns response, or delayed code with hint
// - Different tag runs as a fresh command
// - Initial state forgets earlier tags
// - Controller uses new tag, reuses on retry
// - Unsolicited event packets carry tag zero
// - One command at a time until answered
// - Controller keeps one command outstanding
// - Every well formed command gets a response
// - Held response replaced by each new response
// - Unknown commands unsupported; busy ones unavailable
// - Early response only when values are known
// - Operations complete in arrival order
// - Respond within the normal execution interval
// - Finish operations within not-ready interval
// - Failed completion after response enters initial state
// - Slow answers may be delayed, then polled
// - Delayed command finishes within the completion limit
module sbcr_device
  import sbcr_pkg::*;
#(
  parameter longint NORMAL_CYCLES = NORMAL_EXEC_CYCLES,
  parameter longint OP_CYCLES     = NOT_READY_CYCLES,
  parameter longint DELAY_CYCLES  = DELAY_LIMIT_CYCLES,
  parameter int     TYPE_COUNT    = 8
) (
  // Clock and reset
  input  wire logic       i_clock,
  input  wire logic       i_rst,
  // Link to the controller
  sbcr_if.device          link,
  // Execution engine on the user side
  output logic            o_exec_start,
  output logic [7:0]      o_exec_type,
  output logic [7:0]      o_exec_data,
  input  wire logic       i_exec_done,
  input  wire logic       i_exec_ok,
  input  wire logic [7:0] i_exec_result,
  input  wire logic       i_exec_early,
  input  wire logic       i_busy,
  // Unsolicited events from the user side
  input  wire logic       i_event_valid,
  input  wire logic [7:0] i_event_code,
  output logic            o_event_valid,
  output logic [7:0]      o_event_tag,
  output logic [7:0]      o_event_code,
  // Initial state control and status
  input  wire logic       i_enter_initial,
  input  wire logic       i_clear_initial,
  output logic            o_initial_state
);
  sbcr_state_e state, next_state;
  logic        have_prev, next_have_prev;
  logic [7:0]  prev_tag, next_prev_tag;
  logic [7:0]  r_tag, next_r_tag;
  logic [7:0]  r_type, next_r_type;
  logic [7:0]  r_code, next_r_code;
  logic [7:0]  r_reason, next_r_reason;
  logic [7:0]  r_data, next_r_data;
  logic [15:0] r_hint, next_r_hint;
  logic        delayed, next_delayed;
  logic        early, next_early, was_dly, next_was_dly;    // Last new command went delayed
  logic        init_st, next_init_st;
  logic        start, load_norm, load_op, load_dly, stop_t;
  logic        norm_exp, op_exp, dly_exp;
  logic        take, same_tag;

  assign take     = link.cmd_valid && state == ST_IDLE;
  assign same_tag = have_prev && link.cmd_tag == prev_tag;

  // Deadline timers: normal interval, post-response operation, delayed completion
  sbcr_timer #(.WIDTH(40)) u_norm (
    .i_clock(i_clock), .i_rst(i_rst), .i_load(load_norm),
    .i_count(40'(NORMAL_CYCLES)), .i_stop(stop_t), .o_expired(norm_exp));
  sbcr_timer #(.WIDTH(40)) u_op (
    .i_clock(i_clock), .i_rst(i_rst), .i_load(load_op),
    .i_count(40'(OP_CYCLES)), .i_stop(stop_t), .o_expired(op_exp));
  sbcr_timer #(.WIDTH(40)) u_dly (
    .i_clock(i_clock), .i_rst(i_rst), .i_load(load_dly),
    .i_count(40'(DELAY_CYCLES)), .i_stop(stop_t), .o_expired(dly_exp));

  // Command decode, execution tracking and response formation
  always_comb begin
    next_state     = state;
    next_have_prev = have_prev;
    next_prev_tag  = prev_tag;
    next_r_tag     = r_tag;
    next_r_type    = r_type;
    next_r_code    = r_code;
    next_r_reason  = r_reason;
    next_r_data    = r_data;
    next_r_hint    = r_hint;
    next_delayed   = delayed;
    next_early     = early;
    next_was_dly   = was_dly;
    next_init_st   = init_st;
    start          = 1'b0;
    load_norm      = 1'b0;
    load_op        = 1'b0;
    load_dly       = 1'b0;
    stop_t         = 1'b0;
    if (i_clear_initial) begin
      next_init_st = 1'b0;
    end
    unique case (state)
      ST_IDLE: begin
        if (delayed && i_exec_done) begin                          // Background finish, kept
          next_delayed  = 1'b0;
          stop_t        = 1'b1;
          next_r_code   = i_exec_ok ? RESP_OK : RESP_FAILED;
          next_r_reason = REASON_NONE;
          next_r_data   = i_exec_result;
          next_r_hint   = 16'h0000;
        end else if (dly_exp) begin
          next_delayed = 1'b0;
          next_init_st = 1'b1;
        end else if (early && (i_exec_done || op_exp)) begin
          next_early = 1'b0;
          stop_t     = 1'b1;
          if (!i_exec_ok || op_exp) begin
            next_init_st = 1'b1;
          end
        end
        if (take) begin
          next_r_tag  = link.cmd_tag;
          next_r_type = link.cmd_type;
          next_r_hint = 16'h0000;
          next_state  = ST_RESP;
          if (link.cmd_tag == TAG_EVENT || (link.cmd_poll && !(same_tag && was_dly))) begin
            next_r_code   = RESP_FAILED;
            next_r_reason = (link.cmd_tag == TAG_EVENT) ? REASON_NONE : REASON_NO_CMD;
          end else if (link.cmd_poll || same_tag) begin
            if (next_delayed) begin
              next_r_code   = RESP_DELAYED;
              next_r_reason = REASON_DELAYED;
              next_r_hint   = POLL_HINT_US;
            end
          end else begin
            next_have_prev = 1'b1;
            next_prev_tag  = link.cmd_tag;
            next_was_dly   = 1'b0;
            next_r_data    = 8'h00;
            if (link.cmd_type >= 8'(TYPE_COUNT)) begin
              next_r_code   = RESP_UNSUPPORTED;
              next_r_reason = REASON_UNKNOWN_TYPE;
            end else if (i_busy || next_delayed || next_early) begin
              next_r_code   = RESP_UNAVAILABLE;
              next_r_reason = REASON_NONE;
            end else begin
              start      = 1'b1;
              load_norm  = 1'b1;
              next_early = 1'b0;
              next_state = ST_EXEC;
            end
          end
        end
      end
      ST_EXEC: begin
        if (i_exec_done || i_exec_early) begin
          next_r_code   = (i_exec_done && !i_exec_ok) ? RESP_FAILED : RESP_OK;
          next_r_reason = REASON_NONE;
          next_r_data   = i_exec_result;
          stop_t        = i_exec_done;
          next_early    = !i_exec_done;
          load_op       = !i_exec_done;
          next_state    = ST_RESP;
        end else if (norm_exp) begin
          next_r_code   = RESP_DELAYED;
          next_r_reason = REASON_DELAYED;
          next_r_hint   = POLL_HINT_US;
          next_delayed  = 1'b1;
          next_was_dly  = 1'b1;
          load_dly      = 1'b1;
          next_state    = ST_RESP;
        end
      end
      ST_RESP: begin
        next_state = ST_WAIT;
      end
      ST_WAIT: begin
        if (!link.cmd_valid) begin
          next_state = ST_IDLE;
        end
      end
    endcase
    if (i_enter_initial) begin
      next_init_st = 1'b1;
    end
    if (next_init_st && !init_st) begin
      next_have_prev = 1'b0;
      next_delayed   = 1'b0;
      next_early     = 1'b0;
      next_was_dly   = 1'b0;
    end
  end

  // State registers
  always_ff @(posedge i_clock) begin
    if (i_rst) begin
      state    <= ST_IDLE;
      have_prev <= 1'b0;
      prev_tag <= TAG_EVENT;
      r_tag    <= TAG_EVENT;
      r_type   <= 8'h00;
      r_code   <= RESP_OK;
      r_reason <= REASON_NONE;
      r_data   <= 8'h00;
      r_hint   <= 16'h0000;
      delayed  <= 1'b0;
      early    <= 1'b0;
      was_dly  <= 1'b0;
      init_st  <= 1'b1;
    end else begin
      state    <= next_state;
      have_prev <= next_have_prev;
      prev_tag <= next_prev_tag;
      r_tag    <= next_r_tag;
      r_type   <= next_r_type;
      r_code   <= next_r_code;
      r_reason <= next_r_reason;
      r_data   <= next_r_data;
      r_hint   <= next_r_hint;
      delayed  <= next_delayed;
      early    <= next_early;
      was_dly  <= next_was_dly;
      init_st  <= next_init_st;
    end
  end

  // Execution request, one per fresh command that is not refused, in arrival order
  always_ff @(posedge i_clock) begin
    if (i_rst) begin
      o_exec_start <= 1'b0;
      o_exec_type  <= 8'h00;
      o_exec_data  <= 8'h00;
    end else begin
      o_exec_start <= start;
      if (start) begin
        o_exec_type <= link.cmd_type;
        o_exec_data <= link.cmd_data;
      end
    end
  end

  // Unsolicited events always leave with tag zero
  always_ff @(posedge i_clock) begin
    if (i_rst) begin
      o_event_valid <= 1'b0;
      o_event_tag   <= TAG_EVENT;
      o_event_code  <= 8'h00;
    end else begin
      o_event_valid <= i_event_valid;
      o_event_tag   <= TAG_EVENT;
      o_event_code  <= i_event_code;
    end
  end

  // Link outputs
  assign link.cmd_ready  = state == ST_IDLE;
  assign link.rsp_valid  = state == ST_RESP;
  assign link.rsp_tag    = r_tag;
  assign link.rsp_type   = r_type;
  assign link.rsp_code   = r_code;
  assign link.rsp_reason = r_reason;
  assign link.rsp_data   = r_data;
  assign link.rsp_hint   = r_hint;
  assign o_initial_state = init_st;
endmodule

/* hdl/sbcr_host.sv */
// Controller end: issues commands one at a time with fresh or reused tags
`timescale 1ns/1ps
module sbcr_host
  import sbcr_pkg::*;
(
  // Clock and reset
  input  wire logic        i_clock,
  input  wire logic        i_rst,
  // Link to the device
  sbcr_if.host             link,
  // User command request
  input  wire logic        i_req_valid,
  input  wire logic [7:0]  i_req_type,
  input  wire logic [7:0]  i_req_data,
  input  wire logic        i_req_retry,
  input  wire logic        i_req_poll,
  output logic             o_req_ready,
  // Answer to the user
  output logic             o_ans_valid,
  output logic             o_ans_match,
  output logic [7:0]       o_ans_code,
  output logic [7:0]       o_ans_reason,
  output logic [7:0]       o_ans_data,
  output logic [15:0]      o_ans_hint
);
  sbcr_state_e state, next_state;
  logic [7:0]  tag, next_tag;
  logic [7:0]  c_type, next_c_type;
  logic [7:0]  c_data, next_c_data;
  logic        c_poll, next_c_poll;

  // Issue, hold and wait for the answer
  always_comb begin
    next_state  = state;
    next_tag    = tag;
    next_c_type = c_type;
    next_c_data = c_data;
    next_c_poll = c_poll;
    unique case (state)
      ST_IDLE: begin
        if (i_req_valid) begin
          if (!i_req_retry && !i_req_poll) begin
            next_tag = (tag == TAG_MAX) ? TAG_MIN : tag + 8'h01;
          end
          next_c_type = i_req_type;
          next_c_data = i_req_data;
          next_c_poll = i_req_poll;
          next_state  = ST_EXEC;
        end
      end
      ST_EXEC: begin
        if (link.cmd_ready) begin
          next_state = ST_WAIT;
        end
      end
      ST_WAIT: begin
        if (link.rsp_valid) begin
          next_state = ST_RESP;
        end
      end
      ST_RESP: begin
        next_state = ST_IDLE;
      end
    endcase
  end

  // State registers
  always_ff @(posedge i_clock) begin
    if (i_rst) begin
      state  <= ST_IDLE;
      tag    <= TAG_MAX;
      c_type <= 8'h00;
      c_data <= 8'h00;
      c_poll <= 1'b0;
    end else begin
      state  <= next_state;
      tag    <= next_tag;
      c_type <= next_c_type;
      c_data <= next_c_data;
      c_poll <= next_c_poll;
    end
  end

  // Capture the answer and check its tag
  always_ff @(posedge i_clock) begin
    if (i_rst) begin
      o_ans_valid  <= 1'b0;
      o_ans_match  <= 1'b0;
      o_ans_code   <= 8'h00;
      o_ans_reason <= 8'h00;
      o_ans_data   <= 8'h00;
      o_ans_hint   <= 16'h0000;
    end else begin
      o_ans_valid <= state == ST_WAIT && link.rsp_valid;
      if (state == ST_WAIT && link.rsp_valid) begin
        o_ans_match  <= link.rsp_tag == tag;
        o_ans_code   <= link.rsp_code;
        o_ans_reason <= link.rsp_reason;
        o_ans_data   <= link.rsp_data;
        o_ans_hint   <= link.rsp_hint;
      end
    end
  end

  // Command drive holds from issue until the answer arrives
  assign link.cmd_valid = state == ST_EXEC || state == ST_WAIT;
  assign link.cmd_tag   = tag;
  assign link.cmd_type  = c_type;
  assign link.cmd_poll  = c_poll;
  assign link.cmd_data  = c_data;
  assign o_req_ready    = state == ST_IDLE;
endmodule

/* hdl/sbcr_if.sv */
// Command and response link between controller and device
`timescale 1ns/1ps
interface sbcr_if;
  logic       cmd_valid;
  logic       cmd_ready;
  logic [7:0] cmd_tag;
  logic [7:0] cmd_type;
  logic       cmd_poll;
  logic [7:0] cmd_data;
  logic       rsp_valid;
  logic [7:0] rsp_tag;
  logic [7:0] rsp_type;
  logic [7:0] rsp_code;
  logic [7:0] rsp_reason;
  logic [7:0] rsp_data;
  logic [15:0] rsp_hint;
  modport device (
    input  cmd_valid, cmd_tag, cmd_type, cmd_poll, cmd_data,
    output cmd_ready, rsp_valid, rsp_tag, rsp_type, rsp_code, rsp_reason, rsp_data, rsp_hint
  );
  modport host (
    output cmd_valid, cmd_tag, cmd_type, cmd_poll, cmd_data,
    input  cmd_ready, rsp_valid, rsp_tag, rsp_type, rsp_code, rsp_reason, rsp_data, rsp_hint
  );
endinterface

/* hdl/sbcr_pkg.sv */
// Shared constants and types for the sideband command responder
package sbcr_pkg;
  // Tag values
  localparam logic [7:0] TAG_EVENT   = 8'h00;
  localparam logic [7:0] TAG_MIN     = 8'h01;
  localparam logic [7:0] TAG_MAX     = 8'hFF;
  // Response codes
  localparam logic [7:0] RESP_OK          = 8'h00;
  localparam logic [7:0] RESP_FAILED      = 8'h01;
  localparam logic [7:0] RESP_UNAVAILABLE = 8'h02;
  localparam logic [7:0] RESP_UNSUPPORTED = 8'h03;
  localparam logic [7:0] RESP_DELAYED     = 8'h04;
  // Reason codes
  localparam logic [7:0] REASON_NONE         = 8'h00;
  localparam logic [7:0] REASON_UNKNOWN_TYPE = 8'h01;
  localparam logic [7:0] REASON_NO_CMD       = 8'h02;
  localparam logic [7:0] REASON_DELAYED      = 8'h03;
  // Timing figures in microseconds and derived cycle counts at 250 MHz
  localparam int CLOCK_MHZ                    = 250;
  localparam int NORMAL_EXECUTION_INTERVAL_US = 50000;
  localparam int ASYNC_NOT_READY_INTERVAL_US  = 2000000;
  localparam int DELAYED_COMPLETION_LIMIT_US  = 10000000;
  localparam longint NORMAL_EXEC_CYCLES = longint'(NORMAL_EXECUTION_INTERVAL_US) * CLOCK_MHZ;
  localparam longint NOT_READY_CYCLES   = longint'(ASYNC_NOT_READY_INTERVAL_US) * CLOCK_MHZ;
  localparam longint DELAY_LIMIT_CYCLES = longint'(DELAYED_COMPLETION_LIMIT_US) * CLOCK_MHZ;
  // Suggested next poll interval returned with a delayed answer, in microseconds
  localparam logic [15:0] POLL_HINT_US = 16'h0064;
  // Responder state codes
  typedef enum logic [3:0] {
    ST_IDLE = 4'b0001,
    ST_EXEC = 4'b0010,
    ST_RESP = 4'b0100,
    ST_WAIT = 4'b1000
  } sbcr_state_e;
endpackage

/* hdl/sbcr_timer.sv */
// Down counter that flags when a loaded cycle budget has run out
`timescale 1ns/1ps
module sbcr_timer #(
  parameter int WIDTH = 32
) (
  // Clock and reset
  input  wire logic             i_clock,
  input  wire logic             i_rst,
  // Control
  input  wire logic             i_load,
  input  wire logic [WIDTH-1:0] i_count,
  input  wire logic             i_stop,
  // Status
  output logic                  o_expired
);
  logic [WIDTH-1:0] count;
  logic             run;
  logic [WIDTH-1:0] next_count;
  logic             next_run;
  logic             next_expired;

  // Next count and run state
  always_comb begin
    next_count   = count;
    next_run     = run;
    next_expired = 1'b0;
    if (i_load) begin
      next_count = i_count;
      next_run   = 1'b1;
    end else if (i_stop) begin
      next_run = 1'b0;
    end else if (run) begin
      if (count == '0) begin
        next_expired = 1'b1;
        next_run     = 1'b0;
      end else begin
        next_count = count - 1'b1;
      end
    end
  end

  // Register the counter
  always_ff @(posedge i_clock) begin
    if (i_rst) begin
      count     <= '0;
      run       <= 1'b0;
      o_expired <= 1'b0;
    end else begin
      count     <= next_count;
      run       <= next_run;
      o_expired <= next_expired;
    end
  end
endmodule
